// >>> gpc_pkg.sv
// Shared constants and types for the general-purpose clock loop control block
package gpc_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_LOOPS = 4;
  localparam int unsigned NUM_EXT   = 2;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GPIO   = 8'h08;
  localparam logic [7:0] ADDR_CFG0   = 8'h10;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_DONE_BIT    = 0;
  localparam int unsigned CFG_M_LSB        = 0;
  localparam int unsigned CFG_K_LSB        = 8;
  localparam int unsigned CFG_N_LSB        = 16;
  localparam int unsigned CFG_V_LSB        = 20;
  localparam int unsigned CFG_MODE_LSB     = 24;
  localparam int unsigned CFG_PHASE_LSB    = 26;
  localparam int unsigned CFG_USE_EN_BIT   = 28;
  localparam int unsigned CFG_LOCK_PIN_BIT = 29;
  localparam int unsigned GPIO_OE_LSB      = 4;
  localparam int unsigned GPIO_IN_LSB      = 8;
  localparam int unsigned STAT_BAD_LSB     = 4;
  localparam int unsigned STAT_EN_BIT      = 8;
  localparam int unsigned STAT_REF_OK_BIT  = 9;

  // ---------------------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] GPIO_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0101;
  localparam logic [7:0]  MK_MAX     = 8'hA0;

  // ---------------------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------------------
  localparam int unsigned LOCK_PERIODS = 4;
  localparam int unsigned PERIOD_TOL   = 2;
  localparam int unsigned PERIOD_MIN   = 4;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {GPC_MODE_NORMAL, GPC_MODE_ZDB, GPC_MODE_EXTFB} gpc_mode_e;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> gpc_clock_ctrl.sv
// General-purpose clock loop control: four synthesis loops behind an AXI4-Lite slave
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// Numeric clock synthesiser
// -----------------------------------------------------------------------------
// Outputs above half the system clock rate are held at half that rate; the fine delay step cannot be
// finer than one system clock period.
module gpc_clk_synth #(
  parameter int unsigned PW = 16,
  parameter int unsigned DW = 13
) (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic          run,
  input  wire logic          ref_rise,
  input  wire logic          ext_sync_sel,
  input  wire logic          ext_sync,
  input  wire logic [PW-1:0] period,
  input  wire logic [DW-1:0] div,
  input  wire logic [7:0]    mult,
  input  wire logic [1:0]    phase,
  output logic               clk_o
);
  localparam int unsigned LW = PW + DW;

  logic [LW-1:0] len;
  logic [LW-1:0] step;
  logic [LW-1:0] sum;
  logic [LW-1:0] acc_r;
  logic [DW-1:0] align_r;
  logic          sync_evt;

  always_comb begin
    len      = LW'(period) * LW'(div);
    step     = LW'({mult, 1'b0});
    sum      = acc_r + step;
    sync_evt = ext_sync_sel ? ext_sync : (ref_rise && align_r == '0);
  end

  // Common edge of input and output recurs every div reference periods
  always_ff @(posedge sys_clk) begin
    if (!resetn || !run) begin
      align_r <= '0;
    end else if (ref_rise) begin
      align_r <= (align_r == div - 1'b1) ? '0 : align_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || !run) begin
      acc_r <= '0;
      clk_o <= 1'b0;
    end else if (sync_evt) begin
      acc_r <= phase[0] ? (len >> 1) : '0;
      clk_o <= ~phase[1];
    end else if (sum >= len) begin
      acc_r <= sum - len;
      clk_o <= ~clk_o;
    end else begin
      acc_r <= sum;
    end
  end
endmodule

// -----------------------------------------------------------------------------
// Top level
// -----------------------------------------------------------------------------
module gpc_clock_ctrl #(
  parameter int unsigned PW           = 16,
  parameter int unsigned LOCK_PERIODS = gpc_pkg::LOCK_PERIODS,
  parameter int unsigned PERIOD_TOL   = gpc_pkg::PERIOD_TOL
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ref_clk_pin,
  input  wire logic        global_loop_enable_pin,
  input  wire logic [1:0]  fb_clk_pin,
  input  wire logic [3:0]  lock_pin_in,
  output wire logic [3:0]  loop_first_output,
  output wire logic [3:0]  loop_second_output,
  output wire logic [1:0]  ext_clk_out,
  output wire logic [1:0]  ext_clk_oe,
  output wire logic [3:0]  lock_pin_out,
  output wire logic [3:0]  lock_pin_oe
);
  localparam int unsigned NL = gpc_pkg::NUM_LOOPS;
  localparam int unsigned NE = gpc_pkg::NUM_EXT;
  localparam int unsigned AW = $clog2(LOCK_PERIODS + 1);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [7:0] pins;
  logic [7:0] meta_r;
  logic [7:0] sync_a_r;
  logic [7:0] sync_b_r;
  logic [7:0] filt_r;

  assign pins = {lock_pin_in, fb_clk_pin, global_loop_enable_pin, ref_clk_pin};

  // A change only counts once the last two stages agree, which rejects runts
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r   <= 8'h00;
      sync_a_r <= 8'h00;
      sync_b_r <= 8'h00;
      filt_r   <= 8'h00;
    end else begin
      meta_r   <= pins;
      sync_a_r <= meta_r;
      sync_b_r <= sync_a_r;
      filt_r   <= (~(sync_a_r ^ sync_b_r) & sync_a_r) | ((sync_a_r ^ sync_b_r) & filt_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Reference period measurement
  // ---------------------------------------------------------------------------
  logic          ref_q_r;
  logic [PW-1:0] cnt_r;
  logic [PW-1:0] period_r;
  logic          ref_ok_r;
  logic          ref_rise;
  logic          ref_lost;
  logic          stable;
  logic [PW-1:0] diff;

  always_comb begin
    ref_rise = filt_r[0] & ~ref_q_r;
    ref_lost = (cnt_r == '1);
    diff     = (cnt_r >= period_r) ? cnt_r - period_r : period_r - cnt_r;
    stable   = (diff <= PW'(PERIOD_TOL)) && (cnt_r >= PW'(gpc_pkg::PERIOD_MIN));
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ref_q_r  <= 1'b0;
      cnt_r    <= '0;
      period_r <= '0;
      ref_ok_r <= 1'b0;
    end else begin
      ref_q_r <= filt_r[0];
      if (ref_rise) begin
        cnt_r    <= PW'(1);
        period_r <= cnt_r;
        ref_ok_r <= stable;
      end else if (ref_lost) begin
        ref_ok_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] gpio_r;
  logic [31:0] cfg_r [NL];
  logic        cfg_done;

  assign cfg_done = ctrl_r[gpc_pkg::CTRL_DONE_BIT];

  // ---------------------------------------------------------------------------
  // Loops
  // ---------------------------------------------------------------------------
  logic [1:0] mode_w   [NL];
  logic       syn1_w   [NL];
  logic       first_w  [NL];
  logic       lock_w   [NL];
  logic       bad_w    [NL];
  logic       early_w  [NE];

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_loop
      logic [7:0]  m;
      logic [7:0]  k;
      logic [4:0]  n;
      logic [4:0]  v;
      logic [12:0] nk;
      logic [12:0] nv;
      logic [1:0]  phase;
      logic        unity;
      logic        int_ok;
      logic        bad;
      logic        enabled;
      logic [AW-1:0] acq_r;
      logic        lock_r;
      logic        syn2;
      logic        first_r;
      logic        second_r;
      logic        lpin_r;
      logic        lpin_oe_r;

      always_comb begin
        m      = cfg_r[gi][gpc_pkg::CFG_M_LSB +: 8];
        k      = cfg_r[gi][gpc_pkg::CFG_K_LSB +: 8];
        n      = 5'(cfg_r[gi][gpc_pkg::CFG_N_LSB +: 4]) + 5'h01;
        v      = 5'(cfg_r[gi][gpc_pkg::CFG_V_LSB +: 4]) + 5'h01;
        phase  = cfg_r[gi][gpc_pkg::CFG_PHASE_LSB +: 2];
        nk     = 13'(n) * 13'(k);
        nv     = 13'(n) * 13'(v);
        unity  = (13'(m) == nk);
        int_ok = (m != 8'h00) && nk != 13'h0000 && nv != 13'h0000
                 && ((13'(m) % nk) == 13'h0000 || (nk % 13'(m)) == 13'h0000)
                 && ((13'(m) % nv) == 13'h0000 || (nv % 13'(m)) == 13'h0000);
        bad    = m == 8'h00 || m > gpc_pkg::MK_MAX
                 || k == 8'h00 || k > gpc_pkg::MK_MAX;
        if (mode_w[gi] == 2'h3) begin
          bad = 1'b1;
        end
        if (mode_w[gi] != gpc_pkg::GPC_MODE_NORMAL && (!unity || phase != 2'h0)) begin
          bad = 1'b1;
        end
        if (mode_w[gi] == gpc_pkg::GPC_MODE_EXTFB && (gi % 2) != 0) begin
          bad = 1'b1;
        end
        if (phase != 2'h0 && !int_ok) begin
          bad = 1'b1;
        end
        // Only loops tied to the global enable are gated by it
        enabled = !bad && cfg_done
                  && (!cfg_r[gi][gpc_pkg::CFG_USE_EN_BIT] || filt_r[1]);
      end

      assign mode_w[gi] = cfg_r[gi][gpc_pkg::CFG_MODE_LSB +: 2];
      assign bad_w[gi]  = bad;
      assign lock_w[gi] = lock_r;

      always_ff @(posedge sys_clk) begin
        if (!resetn || !enabled || ref_lost) begin
          acq_r  <= '0;
          lock_r <= 1'b0;
        end else if (ref_rise) begin
          if (!stable) begin
            acq_r  <= '0;
            lock_r <= 1'b0;
          end else begin
            if (acq_r != AW'(LOCK_PERIODS)) begin
              acq_r <= acq_r + 1'b1;
            end
            lock_r <= (acq_r >= AW'(LOCK_PERIODS - 1));
          end
        end
      end

      gpc_clk_synth #(.PW(PW), .DW(13)) u_syn1 (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .run          (lock_r),
        .ref_rise     (ref_rise),
        .ext_sync_sel (mode_w[gi] == gpc_pkg::GPC_MODE_EXTFB),
        .ext_sync     ((gi % 2) == 0 ? early_w[gi / 2] : 1'b0),
        .period       (period_r),
        .div          (nk),
        .mult         (m),
        .phase        (phase),
        .clk_o        (syn1_w[gi])
      );

      gpc_clk_synth #(.PW(PW), .DW(13)) u_syn2 (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .run          (lock_r),
        .ref_rise     (ref_rise),
        .ext_sync_sel (mode_w[gi] == gpc_pkg::GPC_MODE_EXTFB),
        .ext_sync     ((gi % 2) == 0 ? early_w[gi / 2] : 1'b0),
        .period       (period_r),
        .div          (nv),
        .mult         (m),
        .phase        (phase),
        .clk_o        (syn2)
      );

      // Lock pin is either the indicator or plain general I/O
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          first_r   <= 1'b0;
          second_r  <= 1'b0;
          lpin_r    <= 1'b0;
          lpin_oe_r <= 1'b0;
        end else begin
          first_r   <= syn1_w[gi];
          second_r  <= syn2;
          lpin_r    <= cfg_r[gi][gpc_pkg::CFG_LOCK_PIN_BIT] ? lock_r : gpio_r[gi];
          lpin_oe_r <= cfg_done && (cfg_r[gi][gpc_pkg::CFG_LOCK_PIN_BIT]
                       || gpio_r[gpc_pkg::GPIO_OE_LSB + gi]);
        end
      end

      assign first_w[gi]            = first_r;
      assign loop_first_output[gi]  = first_r;
      assign loop_second_output[gi] = second_r;
      assign lock_pin_out[gi]       = lpin_r;
      assign lock_pin_oe[gi]        = lpin_oe_r;
    end

    // -------------------------------------------------------------------------
    // External outputs, one per loop pair, driven by its even loop
    // -------------------------------------------------------------------------
    for (gi = 0; gi < NE; gi++) begin : g_ext
      logic          ext_r;
      logic          ext_oe_r;
      logic          ext_q_r;
      logic          fb_q_r;
      logic          meas_r;
      logic [PW-1:0] dcnt_r;
      logic [PW-1:0] fbdly_r;

      // Resync early by the measured board delay so the feedback pin lands on the input edge
      assign early_w[gi] = (PW'(cnt_r + fbdly_r) == period_r) && fbdly_r != '0;

      always_ff @(posedge sys_clk) begin
        if (!resetn || !cfg_done) begin
          ext_r    <= 1'b0;
          ext_oe_r <= 1'b0;
        end else begin
          ext_oe_r <= 1'b1;
          if (mode_w[2 * gi] == gpc_pkg::GPC_MODE_NORMAL) begin
            ext_r <= first_w[2 * gi];
          end else begin
            ext_r <= syn1_w[2 * gi];
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          ext_q_r <= 1'b0;
          fb_q_r  <= 1'b0;
          meas_r  <= 1'b0;
          dcnt_r  <= '0;
          fbdly_r <= '0;
        end else begin
          ext_q_r <= ext_r;
          fb_q_r  <= filt_r[2 + gi];
          if (ext_r && !ext_q_r) begin
            meas_r <= 1'b1;
            dcnt_r <= '0;
          end else if (meas_r) begin
            if (filt_r[2 + gi] && !fb_q_r) begin
              meas_r  <= 1'b0;
              fbdly_r <= dcnt_r;
            end else if (dcnt_r != '1) begin
              dcnt_r <= dcnt_r + 1'b1;
            end
          end
        end
      end

      assign ext_clk_out[gi] = ext_r;
      assign ext_clk_oe[gi]  = ext_oe_r;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_wr;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [31:0] status;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8 * b +: 8] = data[8 * b +: 8];
      end
    end
    return res;
  endfunction

  assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_comb begin
    status = 32'h0000_0000;
    for (int i = 0; i < NL; i++) begin
      status[i]                        = lock_w[i];
      status[gpc_pkg::STAT_BAD_LSB + i] = bad_w[i];
    end
    status[gpc_pkg::STAT_EN_BIT]     = filt_r[1];
    status[gpc_pkg::STAT_REF_OK_BIT] = ref_ok_r;
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == gpc_pkg::ADDR_CTRL) begin
      rd_val = ctrl_r;
    end else if (s_axi_araddr == gpc_pkg::ADDR_STATUS) begin
      rd_val = status;
    end else if (s_axi_araddr == gpc_pkg::ADDR_GPIO) begin
      rd_val = {20'h00000, filt_r[7:4], gpio_r[7:0]};
    end else if (s_axi_araddr >= gpc_pkg::ADDR_CFG0 && s_axi_araddr[1:0] == 2'h0
                 && s_axi_araddr < gpc_pkg::ADDR_CFG0 + 8'(4 * NL)) begin
      rd_val = cfg_r[s_axi_araddr[3:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end else if (do_wr) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end else if (do_wr) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r       <= gpc_pkg::CTRL_RESET;
      gpio_r       <= gpc_pkg::GPIO_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpc_pkg::RESP_OKAY;
      for (int i = 0; i < NL; i++) begin
        cfg_r[i] <= gpc_pkg::CFG_RESET;
      end
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= gpc_pkg::RESP_OKAY;
      if (awaddr_r == gpc_pkg::ADDR_CTRL) begin
        ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
      end else if (awaddr_r == gpc_pkg::ADDR_GPIO) begin
        gpio_r <= merge(gpio_r, wdata_r, wstrb_r) & 32'h0000_00FF;
      end else if (awaddr_r >= gpc_pkg::ADDR_CFG0 && awaddr_r[1:0] == 2'h0
                   && awaddr_r < gpc_pkg::ADDR_CFG0 + 8'(4 * NL)) begin
        cfg_r[awaddr_r[3:2]] <= merge(cfg_r[awaddr_r[3:2]], wdata_r, wstrb_r)
                                & 32'h3FFF_FFFF;
      end else if (awaddr_r != gpc_pkg::ADDR_STATUS) begin
        s_axi_bresp <= gpc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// >>> gpc_chk_sva.sv
// Checker for bus handshakes and clock gating at the block's ports
`timescale 1ns/1ps
`default_nettype none
module gpc_chk (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       global_loop_enable_pin,
  input wire logic [3:0] loop_first_output,
  input wire logic [1:0] ext_clk_out,
  input wire logic [1:0] ext_clk_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("late write response");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    ##[0:1] s_axi_awready) else $error("bad write retire");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("late read data");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read busy");
  a_out_quiet: assert property ($rose(resetn) |-> ext_clk_oe == 2'h0
    && loop_first_output == 4'h0) else $error("output driven after reset");
  // Loop 0 is always set to obey the global enable by the bench
  a_en_ground: assert property (!global_loop_enable_pin [*8] ##1 !global_loop_enable_pin |->
    !loop_first_output[0] && !ext_clk_out[0]) else $error("loop 0 not grounded");
  a_ext_delay: assert property (ext_clk_oe[0] |->
    ext_clk_out[0] == $past(loop_first_output[0])) else $error("ext clock skew");
  c_first_run: cover property ($fell(loop_first_output[0]));
  c_ext_on: cover property ($rose(ext_clk_oe[0]));
  c_en_off: cover property ($fell(global_loop_enable_pin));
endmodule
bind gpc_clock_ctrl gpc_chk u_gpc_chk (.sys_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .global_loop_enable_pin,
  .loop_first_output, .ext_clk_out, .ext_clk_oe);
`default_nettype wire

// >>> gpc_ref_model.sv
// Reference clock source and board feedback traces
`timescale 1ns/1ps
`default_nettype none
module gpc_ref_model (
  input wire logic       sys_clk,
  input wire logic       run,
  input wire logic [1:0] ext_clk_out,
  input wire logic [1:0] ext_clk_oe,
  output var logic       ref_clk_pin,
  output logic     [1:0] fb_clk_pin
);
  int unsigned cnt = 0;
  // Period of 20 cycles; stands still when stopped to stage a lost input
  always @(posedge sys_clk) begin
    cnt <= (cnt >= 19) ? 0 : cnt + 1;
    ref_clk_pin <= run && (cnt < 10);
  end
  // An undriven trace reads high, because ext_clk_out is held low whenever ext_clk_oe is low
  assign fb_clk_pin = ~(ext_clk_oe ^ ext_clk_out);
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the clock loop control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 0, resetn = 0, run = 1, global_loop_enable_pin = 1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, ref_clk_pin;
  logic        s_axi_bready = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ext_clk_out, ext_clk_oe, fb_clk_pin, r;
  logic [3:0]  loop_first_output, loop_second_output, lock_pin_out, lock_pin_oe;
  logic [3:0]  lock_pin_in = 0;
  int          bad_count = 0, compares = 0, c [4];
  typedef struct {logic [7:0] a; bit w; logic [31:0] d; logic [1:0] r;} gpc_row_s;
  gpc_row_s rows [12] = '{'{8'h00, 0, 32'h0, 2'h0}, '{8'h08, 0, 32'hA00, 2'h0},
    '{8'h10, 0, 32'h101, 2'h0}, '{8'h40, 0, 32'h0, 2'h2}, '{8'h40, 1, 32'h0, 2'h2},
    '{8'h04, 1, 32'h0, 2'h0}, '{8'h11, 1, 32'h0, 2'h2}, '{8'h14, 1, 32'h0, 2'h0},
    '{8'h10, 1, 32'h3030_0102, 2'h0}, '{8'h10, 0, 32'h3030_0102, 2'h0},
    '{8'h08, 1, 32'hF5, 2'h0}, '{8'h08, 0, 32'hAF5, 2'h0}};
  wire logic [3:0] mon = {ext_clk_out[0], loop_first_output[2],
    loop_second_output[0], loop_first_output[0]};
  gpc_clock_ctrl #(.PW(10), .LOCK_PERIODS(2)) u_gpc_clock_ctrl (.sys_clk, .resetn,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ref_clk_pin, .global_loop_enable_pin, .fb_clk_pin, .lock_pin_in, .loop_first_output,
    .loop_second_output, .ext_clk_out, .ext_clk_oe, .lock_pin_out, .lock_pin_oe);
  gpc_ref_model u_gpc_ref_model (.sys_clk, .run, .ext_clk_out, .ext_clk_oe, .ref_clk_pin,
    .fb_clk_pin);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge sys_clk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge sys_clk);
  endtask
  // Polling is bounded; a loop that never locks is caught by the compare after
  task automatic wait_lock();
    for (int n = 0; n < 200 && d[0] !== 1'h1; n++) axr(8'h04);
  endtask
  task automatic rises();
    logic [3:0] p;
    // Skip the first two reference periods after lock, where the outputs are not yet resynced
    repeat (40) @(posedge sys_clk);
    c = '{0, 0, 0, 0}; p = mon;
    repeat (200) begin
      @(posedge sys_clk);
      for (int i = 0; i < 4; i++) c[i] += int'(mon[i] & ~p[i]);
      p = mon;
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1; lock_pin_in <= 4'hA;
    repeat (8) @(posedge sys_clk);
    chk({ext_clk_oe, lock_pin_oe, loop_first_output}, 0);
    foreach (rows[i]) begin
      if (rows[i].w) axw(rows[i].a, rows[i].d);
      else begin axr(rows[i].a); chk(d, rows[i].d); end
      chk(r, rows[i].r);
    end
    chk(lock_pin_out[3:1], 3'h2);
    axw(8'h00, 32'h1);
    d = 0; wait_lock();
    chk(d[5:0], 6'h2D);
    chk({lock_pin_oe, lock_pin_out[0], ext_clk_oe}, 7'h7F);
    rises();
    chk(c[0], 20);
    chk(c[1], 5);
    chk(c[3], 20);
    global_loop_enable_pin <= 0;
    repeat (10) @(posedge sys_clk);
    chk(lock_pin_out[0], 0);
    rises();
    chk(c[0] + c[3], 0);
    chk(c[2], 10);
    global_loop_enable_pin <= 1; d = 0; wait_lock();
    chk(d[0], 1);
    run <= 0;
    repeat (1100) @(posedge sys_clk);
    axr(8'h04);
    chk(d[0], 0);
    report_and_stop();
  end
  initial begin
    #(50 * 20000);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
